// ==== core/crfs_pkg.sv ====
// Shared constants for the card response framer and status word.
package crfs_pkg;

   // -----------------------------------------------------------------
   // Frame lengths and fixed fields
   // -----------------------------------------------------------------
   localparam int unsigned SHORT_LEN  = 48;   // Short response length in bits.
   localparam int unsigned LONG_LEN   = 136;  // Long register response length.
   localparam logic [5:0]  ALL_ONES6  = 6'h3F; // Check-bit filler for index field.
   localparam logic [6:0]  ALL_ONES7  = 7'h7F; // Check-bit filler for CRC field.
   localparam logic [5:0]  FAST_IDX   = 6'h27; // Index of the fast register answer.
   localparam logic [5:0]  IRQ_IDX    = 6'h28; // Index of the interrupt answer.
   localparam logic [6:0]  CRC_POLY   = 7'h09; // Generator x^7 + x^3 + 1.
   localparam logic [6:0]  CRC_INIT   = 7'h00; // Checksum start value.

   // -----------------------------------------------------------------
   // Card status word field positions
   // -----------------------------------------------------------------
   localparam int unsigned ST_RANGE   = 31; // Addr_range_fault.
   localparam int unsigned ST_ALIGN   = 30; // Address misaligned.
   localparam int unsigned ST_BLKLEN  = 29; // Block length fault.
   localparam int unsigned ST_ERSEQ   = 28; // Erase sequence fault.
   localparam int unsigned ST_ERSEL   = 27; // Erase group selection fault.
   localparam int unsigned ST_PROT    = 26; // Protected block write.
   localparam int unsigned ST_LOCKED  = 25; // Card locked (status type).
   localparam int unsigned ST_LOCKF   = 24; // Lock or unlock fault.
   localparam int unsigned ST_CMDCHK  = 23; // Command checksum fault.
   localparam int unsigned ST_ILLEGAL = 22; // Illegal command.
   localparam int unsigned ST_ECC     = 21; // Correction failed.
   localparam int unsigned ST_INTERN  = 20; // Internal fault.
   localparam int unsigned ST_GENERIC = 19; // Generic execution fault.
   localparam int unsigned ST_UNDER   = 18; // Stream read underrun.
   localparam int unsigned ST_OVER    = 17; // Stream write overrun.
   localparam int unsigned ST_IDREW   = 16; // Identity rewrite fault.
   localparam int unsigned ST_SKIP    = 15; // Erase skipped protected areas.
   localparam int unsigned ST_STATE_L = 9;  // Current state field low bit.
   localparam int unsigned ST_READY   = 8;  // Ready for data.
   localparam int unsigned ST_SWITCH  = 7;  // Switch mode fault.

   // Mask of all error-type bits that clear once reported.
   localparam logic [31:0] ERR_MASK   = 32'hFDFF_8080;
   // Card state codes, idle through sleep; above sleep is reserved.
   localparam logic [3:0]  STATE_IDLE  = 4'h0;
   localparam logic [3:0]  STATE_SLEEP = 4'hA;
   localparam logic [31:0] STATUS_RST  = 32'h0000_0000;

   // Response kinds selectable by the command decoder.
   typedef enum logic [2:0] {
      CRFS_R_NORMAL = 3'b000,
      CRFS_R_BUSY   = 3'b001,
      CRFS_R_LONG   = 3'b011,
      CRFS_R_OPCOND = 3'b010,
      CRFS_R_FAST   = 3'b110,
      CRFS_R_IRQ    = 3'b111
   } crfs_kind_e;

   // Framer sequencing states.
   typedef enum logic [1:0] {
      CRFS_IDLE  = 2'b00,
      CRFS_LOAD  = 2'b01,
      CRFS_SHIFT = 2'b11,
      CRFS_DONE  = 2'b10
   } crfs_state_e;

endpackage

// ==== core/crfs_crc7.sv ====
// Serial seven-bit checksum generator for the response framer.
`timescale 1ns/1ps
`default_nettype none
module crfs_crc7 (
   input  wire logic       mclk,   // System clock.
   input  wire logic       rstn,   // Asynchronous reset, active low.
   input  wire logic       clr,    // Restart the checksum at the start value.
   input  wire logic       step,   // Fold one bit in.
   input  wire logic       din,    // Bit to fold in.
   output logic [6:0]      crc     // Running checksum, registered.
);
   import crfs_pkg::*;

   // -----------------------------------------------------------------
   // Shift register
   // -----------------------------------------------------------------
   logic fb; // Feedback bit.

   // Feedback is the incoming bit against the top of the register.
   always_comb begin
      fb = din ^ crc[6];
   end

   // The register advances once per folded bit.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         crc <= CRC_INIT;
      end else if (clr) begin
         crc <= CRC_INIT;
      end else if (step) begin
         crc <= {crc[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
      end
   end
endmodule
`default_nettype wire

// ==== core/crfs_framer.sv ====
// Card response framer and card status word keeper.
// Contract
// [RL1] Shift responses out most significant bit first.
// [RL2] Start bit zero, direction bit zero.
// [RL3] Checksum in bits 7:1, end bit one.
// [RL4] Normal response: 48 bits, index, status.
// [RL5] Busy variant: same frame, optional busy hold.
// [RL6] Long response: 136 bits, ones, register bits.
// [RL7] Long response returns identity or specific register.
// [RL8] Operating conditions response: ones filler, no checksum.
// [RL9] Fast register response: index 100111, argument layout.
// [RL10] Interrupt response: index 101000, address upper.
// [RL11] Error bits clear after reporting response sent.
// [RL12] Status bits persist and track condition.
// [RL13] Interpretation errors reported in own response.
// [RL14] Execution errors reported in next response.
// [RL15] Bits 31 and 30 flag address faults.
// [RL16] Bit 29 flags block length fault.
// [RL17] Bits 28,27,26,15 flag erase and protect faults.
// [RL18] Bit 25 locked, bit 24 lock fault.
// [RL19] Bit 23 command checksum, 22 illegal.
// [RL20] Bits 21,20,19 correction, internal, generic faults.
// [RL21] Bits 18,17 stream underrun and overrun.
// [RL22] Bit 16 flags identity rewrite fault.
// [RL23] Bits 12:9 hold state at command receipt.
// [RL24] Bit 8 shows receive buffer empty.
// [RL25] Bit 7 flags failed mode switch.
// [RL26] Checksum x^7+x^3+1 from start bit, zero start.
// [RL27] Reset clears errors, state field idle.
`timescale 1ns/1ps
`default_nettype none
module crfs_framer (
   input  wire logic                  mclk,          // System clock, 20 MHz.
   input  wire logic                  rstn,          // Asynchronous reset, active low.
   input  wire logic                  bus_clk,       // Host bus clock pin.
   input  wire logic                  resp_req,      // Request to send a response.
   input  wire crfs_pkg::crfs_kind_e  resp_kind,     // Kind of response to send.
   input  wire logic [5:0]            cmd_index,     // Index of the answered command.
   input  wire logic [127:0]          long_reg,      // Identity or specific register.
   input  wire logic [31:0]           op_cond,       // Operating conditions register.
   input  wire logic [15:0]           card_addr,     // Relative card address.
   input  wire logic                  fast_ok,       // Fast register access success.
   input  wire logic [6:0]            fast_addr,     // Fast register address.
   input  wire logic [7:0]            fast_data,     // Fast register read contents.
   input  wire logic [15:0]           irq_data,      // Free interrupt payload.
   input  wire logic                  busy_hold,     // Card wants to hold data line busy.
   input  wire logic [31:0]           resp_err_set,  // Errors found while interpreting.
   input  wire logic [31:0]           exec_err_set,  // Errors found while executing.
   input  wire logic [3:0]            cur_state,     // Card state at command receipt.
   input  wire logic                  locked,        // Card locked condition.
   input  wire logic                  rx_empty,      // Receive buffer empty.
   output logic                       cmd_out,       // Command line drive value.
   output logic                       cmd_oe_n,      // Command line enable, low drives.
   output logic                       dat0_out,      // Data line 0 drive value.
   output logic                       dat0_oe_n,     // Data line 0 enable, low drives.
   output logic                       resp_busy,     // Framer is sending.
   output logic                       resp_done,     // Pulse when end bit has gone.
   output logic [31:0]                card_status_word // Current status word.
);
   import crfs_pkg::*;

   // -----------------------------------------------------------------
   // Bus clock synchroniser and edge detection
   // -----------------------------------------------------------------
   logic       clk_s1;    // First synchroniser stage.
   logic       clk_s2;    // Second synchroniser stage.
   logic       clk_s3;    // Delayed copy for edge finding.
   logic       fall_edge; // Falling edge of the bus clock.

   // Two stages before any logic looks at the pin.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
      end else begin
         clk_s1 <= bus_clk;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
      end
   end

   // Bits change after the falling edge so they are stable at the host rising edge.
   always_comb begin
      fall_edge = clk_s3 & ~clk_s2;
   end

   // -----------------------------------------------------------------
   // Status word
   // -----------------------------------------------------------------
   logic [31:0] err_bits;   // Sticky error bits.
   logic [31:0] snap;       // Status captured for the frame being sent.
   logic        rpt_clear;  // Clear reported errors this cycle.
   logic [31:0] err_in;     // All error events this cycle.

   // Gather the error events from both detection phases.
   always_comb begin
      err_in = (resp_err_set | exec_err_set) & ERR_MASK;
   end

   // Errors are sticky; set wins over the clear after reporting.
   // [RL11] clear after report
   // [RL14] execution errors wait
   // [RL27] reset clears errors
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         err_bits <= STATUS_RST;
      end else if (rpt_clear) begin
         err_bits <= (err_bits & ~snap) | err_in;
      end else begin
         err_bits <= err_bits | err_in;
      end
   end

   // Status fields track the present condition; errors merged in.
   // [RL12] persistent status bits
   // [RL15] [RL16] [RL17] [RL18] error positions
   // [RL19] [RL20] [RL21] [RL22] [RL25] error positions
   // [RL23] state field
   // [RL24] ready for data
   logic [31:0] next_status; // Status word as it stands now.
   always_comb begin
      next_status = err_bits & ERR_MASK;
      next_status[ST_LOCKED] = locked;
      next_status[ST_STATE_L +: 4] = (cur_state > STATE_SLEEP) ? STATE_IDLE : cur_state;
      next_status[ST_READY] = rx_empty;
   end

   // Registered copy shown at the output.
   // [RL27] idle state at reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         card_status_word <= STATUS_RST;
      end else begin
         card_status_word <= next_status;
      end
   end

   // -----------------------------------------------------------------
   // Frame builder
   // -----------------------------------------------------------------
   crfs_state_e state;      // Framer state.
   logic [135:0] shreg;     // Frame, sent from the top bit.
   logic [7:0]   bits_left; // Bits still to send.
   logic [7:0]   crc_pos;   // Bits left when the checksum must be inserted.
   logic         use_crc;   // Frame carries a checksum.
   logic [6:0]   crc;       // Running checksum.
   logic         crc_clr;   // Restart checksum.
   logic         crc_step;  // Fold the bit being sent.
   logic         in_crc;    // Checksum bits are being sent.
   logic [2:0]   crc_cnt;   // Checksum bit index.
   crfs_kind_e   kind_q;    // Kind of frame in flight.
   logic [135:0] next_frame; // Frame assembled from the inputs.
   logic [31:0]  next_arg;   // Argument field of a short frame.
   logic [5:0]   next_idx;   // Index field of a short frame.

   // Assemble the frame, left aligned in the shift register.
   // [RL2] start and direction bits
   // [RL4] normal frame layout
   // [RL6] long frame layout
   // [RL8] conditions filler
   // [RL9] fast register layout
   // [RL10] interrupt layout
   // [RL13] interpretation errors in own answer
   always_comb begin
      next_arg = next_status | (resp_err_set & ERR_MASK);
      next_idx = cmd_index;
      unique case (resp_kind)
         CRFS_R_OPCOND: begin
            next_arg = op_cond;
            next_idx = ALL_ONES6;
         end
         CRFS_R_FAST: begin
            next_arg = {card_addr, fast_ok, fast_addr, fast_data};
            next_idx = FAST_IDX;
         end
         CRFS_R_IRQ: begin
            next_arg = {card_addr, irq_data};
            next_idx = IRQ_IDX;
         end
         CRFS_R_NORMAL, CRFS_R_BUSY, CRFS_R_LONG: begin
            next_idx = cmd_index;
         end
         default: begin
            next_idx = cmd_index;
         end
      endcase
      if (resp_kind == CRFS_R_LONG) begin
         // [RL7] register chosen by decoder
         next_frame = {2'b00, ALL_ONES6, long_reg[127:1], 1'b1};
      end else begin
         next_frame = {2'b00, next_idx, next_arg, ALL_ONES7, 1'b1, 88'h0};
      end
   end

   // Sequencing: wait, load, shift, done.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= CRFS_IDLE;
      end else begin
         unique case (state)
            CRFS_IDLE:  if (resp_req) state <= CRFS_LOAD;
            CRFS_LOAD:  state <= CRFS_SHIFT;
            CRFS_SHIFT: if (fall_edge && bits_left == 8'd1) state <= CRFS_DONE;
            CRFS_DONE:  state <= CRFS_IDLE;
         endcase
      end
   end

   // Load the frame and snapshot the reported status, then shift.
   // [RL1] most significant first
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         shreg     <= '0;
         bits_left <= 8'd0;
         crc_pos   <= 8'd0;
         use_crc   <= 1'b0;
         kind_q    <= CRFS_R_NORMAL;
         snap      <= STATUS_RST;
      end else if (state == CRFS_IDLE && resp_req) begin
         shreg     <= next_frame;
         kind_q    <= resp_kind;
         use_crc   <= (resp_kind != CRFS_R_OPCOND) && (resp_kind != CRFS_R_LONG);
         bits_left <= (resp_kind == CRFS_R_LONG) ? 8'(LONG_LEN) : 8'(SHORT_LEN);
         crc_pos   <= 8'd8;
         snap      <= (resp_kind == CRFS_R_NORMAL || resp_kind == CRFS_R_BUSY) ?
                      ((err_bits | resp_err_set) & ERR_MASK) : 32'h0000_0000;
      end else if (state == CRFS_SHIFT && fall_edge) begin
         shreg     <= {shreg[134:0], 1'b0};
         bits_left <= bits_left - 8'd1;
      end
   end

   // Checksum window covers the seven bits before the end bit.
   always_comb begin
      in_crc   = use_crc && (bits_left <= crc_pos) && (bits_left > 8'd1);
      crc_clr  = (state == CRFS_LOAD);
      crc_step = (state == CRFS_SHIFT) && fall_edge && (bits_left > crc_pos);
      crc_cnt  = 3'(bits_left - 8'd2);
   end

   // [RL26] checksum over start through bit 8
   crfs_crc7 u_crc (
      .mclk (mclk),
      .rstn (rstn),
      .clr  (crc_clr),
      .step (crc_step),
      .din  (shreg[135]),
      .crc  (crc)
   );

   // Drive the line after each falling edge of the bus clock.
   // [RL3] checksum then end bit
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cmd_out  <= 1'b1;
         cmd_oe_n <= 1'b1;
      end else if (state == CRFS_SHIFT && fall_edge) begin
         cmd_oe_n <= 1'b0;
         cmd_out  <= in_crc ? crc[crc_cnt] : shreg[135];
      end else if (state == CRFS_DONE || state == CRFS_IDLE) begin
         cmd_oe_n <= (state == CRFS_IDLE) ? 1'b1 : cmd_oe_n;
         cmd_out  <= 1'b1;
      end
   end

   // Completion pulse and clearing of reported errors.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         resp_done <= 1'b0;
         resp_busy <= 1'b0;
      end else begin
         resp_done <= (state == CRFS_DONE);
         resp_busy <= (state != CRFS_IDLE) || resp_req;
      end
   end

   always_comb begin
      rpt_clear = (state == CRFS_DONE);
   end

   // Busy hold on data line 0 for the busy variant.
   // [RL5] optional busy hold
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dat0_out  <= 1'b1;
         dat0_oe_n <= 1'b1;
      end else begin
         dat0_out  <= 1'b0;
         dat0_oe_n <= !(busy_hold && (kind_q == CRFS_R_BUSY || state == CRFS_IDLE)
                        && (state != CRFS_IDLE || dat0_oe_n == 1'b0));
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_load;
      state == CRFS_IDLE && resp_req;
   endsequence

   chk_start_bit_zero: assert property (@(posedge mclk) disable iff (!rstn) // [RL2]
      (state == CRFS_SHIFT && bits_left == 8'(SHORT_LEN) && fall_edge) |=> (cmd_out == 1'b0))
      else $error("start bit not zero");
   chk_end_bit_one: assert property (@(posedge mclk) disable iff (!rstn) // [RL3]
      (state == CRFS_SHIFT && bits_left == 8'd1 && fall_edge) |=> (cmd_out == 1'b1))
      else $error("end bit not one");
   chk_short_length: assert property (@(posedge mclk) disable iff (!rstn) // [RL4]
      s_load and resp_kind != CRFS_R_LONG |=> bits_left == 8'(SHORT_LEN))
      else $error("short frame length wrong");
   chk_long_length: assert property (@(posedge mclk) disable iff (!rstn) // [RL6]
      s_load and resp_kind == CRFS_R_LONG |=> bits_left == 8'(LONG_LEN))
      else $error("long frame length wrong");
   chk_fast_index: assert property (@(posedge mclk) disable iff (!rstn) // [RL9]
      s_load and resp_kind == CRFS_R_FAST |=> shreg[133:128] == FAST_IDX)
      else $error("fast index wrong");
   chk_irq_index: assert property (@(posedge mclk) disable iff (!rstn) // [RL10]
      s_load and resp_kind == CRFS_R_IRQ |=> shreg[133:128] == IRQ_IDX)
      else $error("interrupt index wrong");
   chk_err_clear: assert property (@(posedge mclk) disable iff (!rstn) // [RL11]
      (state == CRFS_DONE && err_in == 32'h0) |=> ((err_bits & snap) == 32'h0))
      else $error("reported error not cleared");
   chk_err_sticky: assert property (@(posedge mclk) disable iff (!rstn) // [RL14]
      (|err_in) |=> ((err_bits & $past(err_in)) == $past(err_in)))
      else $error("error event lost");
   chk_opcond_fill: assert property (@(posedge mclk) disable iff (!rstn) // [RL8]
      s_load and resp_kind == CRFS_R_OPCOND |=> !use_crc && shreg[133:128] == ALL_ONES6)
      else $error("conditions filler wrong");
endmodule
`default_nettype wire

// ==== testbench/crfs_host_model.sv ====
// Host-side partner: makes the bus clock and samples the command line.
`timescale 1ns/1ps
`default_nettype none
module crfs_host_model (
   input  wire logic         run,      // Bus clock runs while high.
   input  wire logic         clr,      // Clears the capture, active high.
   input  wire logic         cmd_out,  // Card command line value.
   input  wire logic         cmd_oe_n, // Card drives the line when low.
   output logic              bus_clk,  // Host bus clock, 400 ns period.
   output logic [135:0]      frame,    // Captured bits, last bit in bit 0.
   output logic [8:0]        nbits     // Number of bits captured.
);
   // -----------------------------------------------------------------
   // Line level and clock
   // -----------------------------------------------------------------
   logic line; // Pull-up makes a released line read one.
   assign line = cmd_oe_n ? 1'b1 : cmd_out;

   // The clock stands still high between frames and runs only within them.
   initial begin
      bus_clk = 1'b1;
      forever begin
         #200;
         if (run || !bus_clk) begin
            bus_clk = ~bus_clk;
         end
      end
   end

   // -----------------------------------------------------------------
   // Capture
   // -----------------------------------------------------------------
   // first bit lands highest
   always @(posedge bus_clk or posedge clr) begin
      if (clr) begin
         frame <= '0;
         nbits <= '0;
      end else if (!cmd_oe_n) begin
         frame <= {frame[134:0], line};
         nbits <= nbits + 9'h001;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the response framer and status word.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import crfs_pkg::*;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic mclk, rstn, bus_clk, resp_req, fast_ok, busy_hold, locked, rx_empty;
   logic run, clr, cmd_out, cmd_oe_n, dat0_out, dat0_oe_n, resp_busy, resp_done;
   crfs_kind_e    resp_kind;   // Requested response kind.
   logic [5:0]    cmd_index;   // Answered command index.
   logic [127:0]  long_reg;    // Long register contents.
   logic [31:0]   op_cond, resp_err_set, exec_err_set, card_status_word;
   logic [15:0]   card_addr, irq_data;
   logic [6:0]    fast_addr;   // Fast access register address.
   logic [7:0]    fast_data;   // Fast access read contents.
   logic [3:0]    cur_state;   // Card state code.
   logic [135:0]  frame;       // Frame seen by the host.
   logic [8:0]    nbits;       // Bits seen by the host.
   int            err_total;   // Mismatches counted.
   int            check_count; // Comparisons made.
   logic [31:0]   base;        // Status levels expected outside errors.

   crfs_framer u_dut (.mclk(mclk), .rstn(rstn), .bus_clk(bus_clk), .resp_req(resp_req),
      .resp_kind(resp_kind), .cmd_index(cmd_index), .long_reg(long_reg), .op_cond(op_cond),
      .card_addr(card_addr), .fast_ok(fast_ok), .fast_addr(fast_addr), .fast_data(fast_data),
      .irq_data(irq_data), .busy_hold(busy_hold), .resp_err_set(resp_err_set),
      .exec_err_set(exec_err_set), .cur_state(cur_state), .locked(locked),
      .rx_empty(rx_empty), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n), .dat0_out(dat0_out),
      .dat0_oe_n(dat0_oe_n), .resp_busy(resp_busy), .resp_done(resp_done),
      .card_status_word(card_status_word));
   crfs_host_model u_host (.run(run), .clr(clr), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
      .bus_clk(bus_clk), .frame(frame), .nbits(nbits));

   // The system clock runs at 20 MHz.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Serial checksum, generator x^7 + x^3 + 1, start value zero.
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      logic       fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
      end
      return c;
   endfunction

   // Builds a checked short frame from index and argument.
   function automatic logic [135:0] shortf(input logic [5:0] idx, input logic [31:0] arg);
      return {88'h0, 2'b00, idx, arg, crc7({2'b00, idx, arg}), 1'b1};
   endfunction

   // Prints the verdict and ends the run.
   task automatic report_and_stop;
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Compares a seen value against the expected one.
   task automatic check(input logic [135:0] seen, input logic [135:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Compares the status word after a few settling cycles.
   task automatic chk_status(input logic [31:0] exp);
      repeat (3) @(posedge mclk);
      #1;
      check({104'h0, card_status_word}, {104'h0, exp});
   endtask

   // Requests one response, lets the host clock it out, checks the frame.
   task automatic send(input crfs_kind_e k, input logic [31:0] rerr,
                       input logic [135:0] exp, input logic [8:0] len);
      int i;
      clr = 1'b1;
      run = 1'b1;
      resp_kind = k;
      resp_req = 1'b1;
      resp_err_set = rerr;
      @(posedge mclk);
      #1;
      clr = 1'b0;
      resp_req = 1'b0;
      resp_err_set = '0;
      check({135'h0, resp_busy}, 136'h1);
      for (i = 0; i < 3000; i++) begin
         @(posedge mclk);
         #1;
         if (resp_done === 1'b1) break;
      end
      #1;
      run = 1'b0;
      if (i == 3000) begin
         err_total++;
         $display("[FAIL] t=%0t no completion", $time);
         report_and_stop();
      end
      repeat (20) @(posedge mclk);
      #1;
      check(frame, exp);
      check({127'h0, nbits}, {127'h0, len});
      check({135'h0, cmd_oe_n}, 136'h1);
      check({135'h0, resp_busy}, 136'h0);
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      err_total = 0;
      check_count = 0;
      {rstn, resp_req, fast_ok, busy_hold, locked, rx_empty, run, clr} = '0;
      resp_kind = CRFS_R_NORMAL;
      {cmd_index, long_reg, op_cond, resp_err_set, exec_err_set} = '0;
      {card_addr, irq_data, fast_addr, fast_data, cur_state} = '0;
      repeat (2) @(posedge mclk);
      #1;
      rstn = 1'b1;
      chk_status(32'h0000_0000);
      locked = 1'b1;
      rx_empty = 1'b1;
      cur_state = 4'hB;
      chk_status(32'h0200_0100);
      cur_state = 4'h5;
      base = 32'h0200_0B00;
      chk_status(base);
      cmd_index = 6'h0D;
      send(CRFS_R_NORMAL, 32'h0040_0000, shortf(6'h0D, base | 32'h0040_0000), 9'd48);
      chk_status(base);
      exec_err_set = 32'hFFFF_FFFF;
      @(posedge mclk);
      #1;
      exec_err_set = '0;
      chk_status(base | ERR_MASK);
      cmd_index = 6'h0C;
      busy_hold = 1'b1;
      send(CRFS_R_BUSY, 32'h0000_0000, shortf(6'h0C, base | ERR_MASK), 9'd48);
      chk_status(base);
      check({134'h0, dat0_oe_n, dat0_out}, 136'h0);
      busy_hold = 1'b0;
      chk_status(base);
      check({135'h0, dat0_oe_n}, 136'h1);
      long_reg = 128'hF00D_1234_5678_9ABC_DEF0_0F1E_2D3C_4B5B;
      send(CRFS_R_LONG, 32'h0, {2'b00, 6'h3F, long_reg[127:1], 1'b1}, 9'd136);
      op_cond = 32'h80FF_8000;
      send(CRFS_R_OPCOND, 32'h0, {88'h0, 2'b00, 6'h3F, op_cond, 7'h7F, 1'b1}, 9'd48);
      card_addr = 16'hA5C3;
      fast_ok = 1'b1;
      fast_addr = 7'h15;
      fast_data = 8'h3C;
      send(CRFS_R_FAST, 32'h0, shortf(FAST_IDX, {16'hA5C3, 1'b1, 7'h15, 8'h3C}), 9'd48);
      card_addr = 16'h0000;
      irq_data = 16'hBEEF;
      send(CRFS_R_IRQ, 32'h0, shortf(IRQ_IDX, 32'h0000_BEEF), 9'd48);
      report_and_stop();
   end
endmodule
`default_nettype wire
